// [logic/cfs_pkg.sv]
// package: register map, field layouts, reset values and decode constants of the charger status bank
package cfs_pkg;

    // ************************************************************
    // register offsets
    // ************************************************************
    localparam logic [7:0] ADDR_FAULT   = 8'h09;
    localparam logic [7:0] ADDR_INPUT   = 8'h0A;
    localparam logic [7:0] ADDR_PART    = 8'h0B;
    localparam logic [7:0] ADDR_TEMPCTL = 8'h0C;

    // ************************************************************
    // field codes and reset values
    // ************************************************************
    localparam logic [1:0] CHG_FAULT_NONE    = 2'h0;
    localparam logic [1:0] CHG_FAULT_INPUT   = 2'h1;
    localparam logic [1:0] CHG_FAULT_THERMAL = 2'h2;
    localparam logic [1:0] CHG_FAULT_TIMER   = 2'h3;
    localparam logic [2:0] ZONE_NORMAL       = 3'h0;
    localparam logic [2:0] ZONE_WARM         = 3'h2;
    localparam logic [2:0] ZONE_COOL         = 3'h3;
    localparam logic [7:0] TEMPCTL_RESET     = 8'h75;
    localparam logic       MASK_RESET        = 1'h0;
    localparam logic [7:0] READ_ZERO         = 8'h00;

    // warm current scale, percent of programmed charge current
    localparam logic [6:0] PCT_0   = 7'h00;
    localparam logic [6:0] PCT_20  = 7'h14;
    localparam logic [6:0] PCT_50  = 7'h32;
    localparam logic [6:0] PCT_100 = 7'h64;

    // thermistor thresholds in hundredths of a percent of the reference
    localparam logic [12:0] COOL_THR_0 = 13'h1BA3; // 70.75
    localparam logic [12:0] COOL_THR_1 = 13'h1AA9; // 68.25
    localparam logic [12:0] COOL_THR_2 = 13'h197D; // 65.25
    localparam logic [12:0] COOL_THR_3 = 13'h1851; // 62.25
    localparam logic [12:0] WARM_THR_0 = 13'h12D9; // 48.25
    localparam logic [12:0] WARM_THR_1 = 13'h117B; // 44.75
    localparam logic [12:0] WARM_THR_2 = 13'h0FEB; // 40.75
    localparam logic [12:0] WARM_THR_3 = 13'h0EBF; // 37.75

    // ************************************************************
    // carriers
    // ************************************************************
    typedef struct packed {
        logic wdog_expired;
        logic boost_overload;
        logic bus_overvolt;
        logic bat_low_boost;
        logic input_overvolt;
        logic input_undervolt;
        logic thermal_shutdown;
        logic safety_expired;
        logic battery_overvolt;
        logic zone_warm;
        logic zone_cool;
        logic buck_mode;
        logic good_input_attached;
        logic input_volt_loop_active;
        logic input_curr_loop_active;
        logic final_charge_timer_running;
        logic adaptor_overvolt;
    } cfs_pins_t;

    typedef struct packed {
        logic       wdog_fault;
        logic       boost_fault;
        logic [1:0] charge_fault_code;
        logic       battery_overvolt_flag;
        logic [2:0] zone;
    } cfs_fault_reg_t;

    typedef struct packed {
        logic good_input_attached;
        logic input_volt_loop_active;
        logic input_curr_loop_active;
        logic rsvd;
        logic final_charge_timer_running;
        logic adaptor_overvolt_flag;
        logic input_volt_event_mask;
        logic input_curr_event_mask;
    } cfs_input_reg_t;

    typedef struct packed {
        logic       reg_reset;
        logic [3:0] part_id_field;
        logic       rsvd;
        logic [1:0] revision_field;
    } cfs_part_reg_t;

    typedef struct packed {
        logic       cool_voltage_select;
        logic       cool_charge_enable;
        logic [1:0] warm_current_scale;
        logic [1:0] cool_threshold_select;
        logic [1:0] warm_threshold_select;
    } cfs_tctrl_t;

    typedef struct packed {
        logic        cool_voltage_limit;
        logic        charge_inhibit;
        logic [6:0]  current_pct;
        logic        timer_double_ok;
        logic [12:0] cool_threshold;
        logic [12:0] warm_threshold;
    } cfs_charge_ctl_t;

endpackage

// [logic/cfs_sync.sv]
// module: two-stage synchroniser for a vector of pin levels
`timescale 1ns/1ns
module cfs_sync #(
    parameter int W = 1
) (
    input  wire logic         i_clk,
    input  wire logic         i_rst,
    input  wire logic [W-1:0] i_async,
    output logic      [W-1:0] o_sync
);

    // ************************************************************
    // one flop pair per bit
    // ************************************************************
    for (genvar g = 0; g < W; g++)
    begin : g_bit
        logic meta_r;
        logic sync_r;
        // first stage feeds only the second stage
        always_ff @(posedge i_clk or posedge i_rst)
        begin
            if (i_rst)
            begin
                meta_r <= 1'b0;
                sync_r <= 1'b0;
            end
            else
            begin
                meta_r <= i_async[g];
                sync_r <= meta_r;
            end
        end
        assign o_sync[g] = sync_r;
    end

endmodule // cfs_sync

// [logic/cfs_zone_ctl.sv]
// module: decode of temperature-zone control fields into charge settings
`timescale 1ns/1ns
module cfs_zone_ctl (
    input  wire cfs_pkg::cfs_tctrl_t      i_tctrl,
    input  wire logic                     i_warm,
    input  wire logic                     i_cool,
    output cfs_pkg::cfs_charge_ctl_t      o_ctl
);

    // ************************************************************
    // zone dependent settings
    // ************************************************************
    always_comb
    begin
        o_ctl = '0;
        o_ctl.cool_voltage_limit = i_cool && i_tctrl.cool_voltage_select;
        o_ctl.charge_inhibit     = i_cool && !i_tctrl.cool_charge_enable;
        o_ctl.timer_double_ok    = !i_warm;
        o_ctl.current_pct = cfs_pkg::PCT_100;
        if (i_warm)
        begin
            case (i_tctrl.warm_current_scale)
                2'h0:    o_ctl.current_pct = cfs_pkg::PCT_0;
                2'h1:    o_ctl.current_pct = cfs_pkg::PCT_20;
                2'h2:    o_ctl.current_pct = cfs_pkg::PCT_50;
                default: o_ctl.current_pct = cfs_pkg::PCT_100;
            endcase
        end
        case (i_tctrl.cool_threshold_select)
            2'h0:    o_ctl.cool_threshold = cfs_pkg::COOL_THR_0;
            2'h1:    o_ctl.cool_threshold = cfs_pkg::COOL_THR_1;
            2'h2:    o_ctl.cool_threshold = cfs_pkg::COOL_THR_2;
            default: o_ctl.cool_threshold = cfs_pkg::COOL_THR_3;
        endcase
        case (i_tctrl.warm_threshold_select)
            2'h0:    o_ctl.warm_threshold = cfs_pkg::WARM_THR_0;
            2'h1:    o_ctl.warm_threshold = cfs_pkg::WARM_THR_1;
            2'h2:    o_ctl.warm_threshold = cfs_pkg::WARM_THR_2;
            default: o_ctl.warm_threshold = cfs_pkg::WARM_THR_3;
        endcase
    end

endmodule // cfs_zone_ctl

// [logic/cfs_regs.sv]
// module: charger fault, status, part information and temperature control register bank
//
// What this block does
// - watchdog fault bit reads 1 after watchdog expiry, else 0
// - boost fault bit set on overload, bus over-voltage or low battery
// - charge fault code: 00 none, 01 input, 10 thermal, 11 timer
// - battery fault bit follows battery over-voltage
// - zone field 000 normal, 010 warm, 011 cool, buck mode only
// - good input bit follows valid input supply attached
// - voltage loop status bit follows input voltage regulation
// - current loop status bit follows input current regulation
// - final charge timer bit follows top-off timer running
// - adaptor over-voltage bit follows input over-voltage detection
// - voltage loop event pulse suppressed while its mask is 1
// - current loop event pulse suppressed while its mask is 1
// - writing 1 resets writable bits, restarts safety timer, self-clears
// - cool zone voltage capped at 4.1V when select bit is 1
// - cool zone charging inhibited when enable bit is 0
// - warm zone current scaled 0, 20, 50 or 100 percent
// - safety timer never doubled in the warm zone
// - cool threshold from 70.75, 68.25, 65.25, 62.25 percent
// - warm threshold from 48.25, 44.75, 40.75, 37.75 percent
`timescale 1ns/1ns
module cfs_regs #(
    parameter logic [3:0] PART_ID  = 4'hA, // arbitrary value
    parameter logic [1:0] REVISION = 2'h2, // arbitrary value
    parameter int         SYNC_W   = 17
) (
    input  wire logic                      I_REF_CLK,
    input  wire logic                      I_RST,
    input  wire logic [7:0]                I_ADDR,
    input  wire logic                      I_WR_EN,
    input  wire logic [7:0]                I_WR_DATA,
    input  wire logic                      I_RD_EN,
    input  wire cfs_pkg::cfs_pins_t        I_STATUS_PINS,
    output logic      [7:0]                O_RD_DATA,
    output logic                           O_RD_VALID,
    output logic                           O_VOLT_EVENT_IRQ,
    output logic                           O_CURR_EVENT_IRQ,
    output logic                           O_SAFETY_TIMER_RESTART,
    output cfs_pkg::cfs_charge_ctl_t       O_CHARGE_CTL
);

    // ************************************************************
    // elaboration checks
    // ************************************************************
    if (SYNC_W != $bits(cfs_pkg::cfs_pins_t))
    begin : g_bad_width
        $error("SYNC_W must equal the pin carrier width");
    end

    // ************************************************************
    // pin synchronisers
    // ************************************************************
    logic [SYNC_W-1:0]    pins_sync;
    cfs_pkg::cfs_pins_t   pins;

    // every status level comes from the analogue side, so two flops first
    cfs_sync #(
        .W       (SYNC_W)
    ) u_sync (
        .i_clk   (I_REF_CLK),
        .i_rst   (I_RST),
        .i_async (I_STATUS_PINS),
        .o_sync  (pins_sync)
    );
    assign pins = cfs_pkg::cfs_pins_t'(pins_sync);

    // ************************************************************
    // live fault and status images
    // ************************************************************
    cfs_pkg::cfs_fault_reg_t fault_img;
    cfs_pkg::cfs_input_reg_t input_img;
    cfs_pkg::cfs_part_reg_t  part_img;
    logic                    zone_warm;
    logic                    zone_cool;

    // zones only count while the buck converter charges
    assign zone_warm = pins.buck_mode && pins.zone_warm;
    assign zone_cool = pins.buck_mode && pins.zone_cool && !pins.zone_warm;

    // fault register built from live conditions each read
    always_comb
    begin
        fault_img = '0;
        fault_img.wdog_fault = pins.wdog_expired;
        fault_img.boost_fault = pins.boost_overload || pins.bus_overvolt
                              || pins.bat_low_boost;
        if (pins.input_overvolt || pins.input_undervolt)
            fault_img.charge_fault_code = cfs_pkg::CHG_FAULT_INPUT;
        else if (pins.thermal_shutdown)
            fault_img.charge_fault_code = cfs_pkg::CHG_FAULT_THERMAL;
        else if (pins.safety_expired)
            fault_img.charge_fault_code = cfs_pkg::CHG_FAULT_TIMER;
        else
            fault_img.charge_fault_code = cfs_pkg::CHG_FAULT_NONE;
        fault_img.battery_overvolt_flag = pins.battery_overvolt;
        if (zone_warm)
            fault_img.zone = cfs_pkg::ZONE_WARM;
        else if (zone_cool)
            fault_img.zone = cfs_pkg::ZONE_COOL;
        else
            fault_img.zone = cfs_pkg::ZONE_NORMAL;
    end

    logic vmask_r;
    logic cmask_r;
    logic reg_rst_r;

    // input status register, live bits plus stored masks
    always_comb
    begin
        input_img = '0;
        input_img.good_input_attached = pins.good_input_attached;
        input_img.input_volt_loop_active = pins.input_volt_loop_active;
        input_img.input_curr_loop_active = pins.input_curr_loop_active;
        input_img.final_charge_timer_running = pins.final_charge_timer_running;
        input_img.adaptor_overvolt_flag = pins.adaptor_overvolt;
        input_img.input_volt_event_mask = vmask_r;
        input_img.input_curr_event_mask = cmask_r;
    end

    // part register, identity fields are fixed parameters
    always_comb
    begin
        part_img                = '0;
        part_img.reg_reset      = reg_rst_r;
        part_img.part_id_field  = PART_ID;
        part_img.revision_field = REVISION;
    end

    // ************************************************************
    // write decode
    // ************************************************************
    logic wr_input;
    logic wr_part;
    logic wr_tctrl;

    assign wr_input = I_WR_EN && (I_ADDR == cfs_pkg::ADDR_INPUT);
    assign wr_part  = I_WR_EN && (I_ADDR == cfs_pkg::ADDR_PART);
    assign wr_tctrl = I_WR_EN && (I_ADDR == cfs_pkg::ADDR_TEMPCTL);

    // write data seen through the register layouts, so no bit index is hard coded
    cfs_pkg::cfs_part_reg_t  wr_part_fields;
    cfs_pkg::cfs_input_reg_t wr_input_fields;

    assign wr_part_fields  = cfs_pkg::cfs_part_reg_t'(I_WR_DATA);
    assign wr_input_fields = cfs_pkg::cfs_input_reg_t'(I_WR_DATA);

    // ************************************************************
    // register reset sequencer
    // ************************************************************
    // one-cycle self-clearing reset
    always_ff @(posedge I_REF_CLK or posedge I_RST)
    begin
        if (I_RST)
            reg_rst_r <= 1'b0;
        else if (reg_rst_r)
            reg_rst_r <= 1'b0;
        else
            reg_rst_r <= wr_part && wr_part_fields.reg_reset;
    end

    always_ff @(posedge I_REF_CLK or posedge I_RST)
    begin
        if (I_RST)
            O_SAFETY_TIMER_RESTART <= 1'b0;
        else
            O_SAFETY_TIMER_RESTART <= reg_rst_r;
    end

    // ************************************************************
    // interrupt masks
    // ************************************************************
    // masks survive watchdog expiry; only register reset clears them
    always_ff @(posedge I_REF_CLK or posedge I_RST)
    begin
        if (I_RST)
        begin
            vmask_r <= cfs_pkg::MASK_RESET;
            cmask_r <= cfs_pkg::MASK_RESET;
        end
        else if (reg_rst_r)
        begin
            vmask_r <= cfs_pkg::MASK_RESET;
            cmask_r <= cfs_pkg::MASK_RESET;
        end
        else if (wr_input)
        begin
            vmask_r <= wr_input_fields.input_volt_event_mask;
            cmask_r <= wr_input_fields.input_curr_event_mask;
        end
    end

    // ************************************************************
    // temperature zone control
    // ************************************************************
    cfs_pkg::cfs_tctrl_t tctrl_r;

    always_ff @(posedge I_REF_CLK or posedge I_RST)
    begin
        if (I_RST)
            tctrl_r <= cfs_pkg::TEMPCTL_RESET;
        else if (reg_rst_r || pins.wdog_expired)
            tctrl_r <= cfs_pkg::TEMPCTL_RESET;
        else if (wr_tctrl)
            tctrl_r <= cfs_pkg::cfs_tctrl_t'(I_WR_DATA);
    end

    cfs_pkg::cfs_charge_ctl_t ctl_nxt;

    cfs_zone_ctl u_zone (
        .i_tctrl (tctrl_r),
        .i_warm  (zone_warm),
        .i_cool  (zone_cool),
        .o_ctl   (ctl_nxt)
    );

    // registered so the analogue side sees glitch-free settings
    always_ff @(posedge I_REF_CLK or posedge I_RST)
    begin
        if (I_RST)
            O_CHARGE_CTL <= '0;
        else
            O_CHARGE_CTL <= ctl_nxt;
    end

    // ************************************************************
    // loop event interrupts
    // ************************************************************
    logic vloop_d_r;
    logic cloop_d_r;
    logic vloop_rise;
    logic cloop_rise;

    // edges are taken on the second sync stage, never the first
    always_ff @(posedge I_REF_CLK or posedge I_RST)
    begin
        if (I_RST)
        begin
            vloop_d_r <= 1'b0;
            cloop_d_r <= 1'b0;
        end
        else
        begin
            vloop_d_r <= pins.input_volt_loop_active;
            cloop_d_r <= pins.input_curr_loop_active;
        end
    end
    assign vloop_rise = pins.input_volt_loop_active && !vloop_d_r;
    assign cloop_rise = pins.input_curr_loop_active && !cloop_d_r;

    always_ff @(posedge I_REF_CLK or posedge I_RST)
    begin
        if (I_RST)
        begin
            O_VOLT_EVENT_IRQ <= 1'b0;
            O_CURR_EVENT_IRQ <= 1'b0;
        end
        else
        begin
            O_VOLT_EVENT_IRQ <= vloop_rise && !vmask_r;
            O_CURR_EVENT_IRQ <= cloop_rise && !cmask_r;
        end
    end

    // ************************************************************
    // read path
    // ************************************************************
    logic [7:0] rd_nxt;

    // unmapped offsets read as zero
    always_comb
    begin
        if (I_ADDR == cfs_pkg::ADDR_FAULT)
            rd_nxt = fault_img;
        else if (I_ADDR == cfs_pkg::ADDR_INPUT)
            rd_nxt = input_img;
        else if (I_ADDR == cfs_pkg::ADDR_PART)
            rd_nxt = part_img;
        else if (I_ADDR == cfs_pkg::ADDR_TEMPCTL)
            rd_nxt = tctrl_r;
        else
            rd_nxt = cfs_pkg::READ_ZERO;
    end

    always_ff @(posedge I_REF_CLK or posedge I_RST)
    begin
        if (I_RST)
        begin
            O_RD_DATA  <= cfs_pkg::READ_ZERO;
            O_RD_VALID <= 1'b0;
        end
        else
        begin
            O_RD_VALID <= I_RD_EN;
            if (I_RD_EN)
                O_RD_DATA <= rd_nxt;
        end
    end

    // ************************************************************
    // assertions
    // ************************************************************
    default clocking cb @(posedge I_REF_CLK);
    endclocking
    default disable iff (I_RST);

    sequence s_rst_req;
        wr_part && wr_part_fields.reg_reset && !reg_rst_r;
    endsequence

    sequence s_rst_done;
        reg_rst_r ##1 (!reg_rst_r && O_SAFETY_TIMER_RESTART);
    endsequence

    chk_rst_self_clear: assert property (s_rst_req |=> s_rst_done)
        else $error("register reset did not self-clear with timer restart");

    chk_rst_defaults: assert property (
        reg_rst_r |=> (tctrl_r == cfs_pkg::TEMPCTL_RESET) && !vmask_r && !cmask_r)
        else $error("register reset left writable bits off default");

    chk_wdog_defaults: assert property (pins.wdog_expired |=> tctrl_r == cfs_pkg::TEMPCTL_RESET)
        else $error("watchdog expiry did not restore temperature controls");

    chk_vmask_gate: assert property (vloop_rise |=> O_VOLT_EVENT_IRQ == !$past(vmask_r))
        else $error("voltage loop event pulse disagrees with mask");

    chk_cmask_gate: assert property (cloop_rise |=> O_CURR_EVENT_IRQ == !$past(cmask_r))
        else $error("current loop event pulse disagrees with mask");

    chk_fault_read: assert property (
        I_RD_EN && I_ADDR == cfs_pkg::ADDR_FAULT |=> O_RD_VALID && O_RD_DATA == $past(fault_img))
        else $error("fault register read returned stale data");

    chk_zone_buck: assert property (!pins.buck_mode |-> fault_img.zone == cfs_pkg::ZONE_NORMAL)
        else $error("zone reported outside buck mode");

    chk_warm_timer: assert property (zone_warm |=> !O_CHARGE_CTL.timer_double_ok)
        else $error("timer doubling allowed in warm zone");

    chk_cool_inhibit: assert property (
        zone_cool && !tctrl_r.cool_charge_enable |=> O_CHARGE_CTL.charge_inhibit)
        else $error("cool zone charging not inhibited");

    chk_boost_fault: assert property (pins.bat_low_boost |-> fault_img.boost_fault)
        else $error("boost fault missed low battery");

endmodule // cfs_regs

// [test/cfs_host.sv]
// host model: strobe-port register reads and writes on the charger bank
`timescale 1ns/1ns
module cfs_host (
    input  wire logic       i_clk,
    input  wire logic [7:0] i_rd_data,
    input  wire logic       i_rd_valid,
    output logic      [7:0] o_addr,
    output logic            o_wr_en,
    output logic      [7:0] o_wr_data,
    output logic            o_rd_en
);
    // idle bus at time zero
    initial
    begin
        o_addr    = 8'h00;
        o_wr_en   = 1'b0;
        o_wr_data = 8'h00;
        o_rd_en   = 1'b0;
    end

    // one-cycle write strobe, launched just after an edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clk);
        #2;
        o_addr    = a;
        o_wr_data = d;
        o_wr_en   = 1'b1;
        @(posedge i_clk);
        #2;
        o_wr_en   = 1'b0;
        o_wr_data = ~d; // released data never shows the last value
    endtask

    // one-cycle read strobe; data taken only when valid answers
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge i_clk);
        #2;
        o_addr  = a;
        o_rd_en = 1'b1;
        @(posedge i_clk);
        #2;
        o_rd_en = 1'b0;
        d       = i_rd_valid ? i_rd_data : 8'hxx;
    endtask
endmodule // cfs_host

// [test/testbench.sv]
// testbench: register-level checks of the charger status bank
`timescale 1ns/1ns
module testbench;
    logic                     clk = 1'b0;
    logic                     rst = 1'b1;
    logic [16:0]              pins = 17'h0_0000;
    cfs_pkg::cfs_charge_ctl_t ctl;
    logic [7:0]               addr, wdat, rdat, got;
    logic                     wen, ren, rvld, virq, cirq, srst;
    int                       bad_count = 0;
    int                       comparisons = 0;
    int                       cycles = 0, vcnt = 0, ccnt = 0, scnt = 0;

    always #25 clk = ~clk;

    cfs_host cfs_host_inst (.i_clk(clk), .i_rd_data(rdat), .i_rd_valid(rvld), .o_addr(addr),
        .o_wr_en(wen), .o_wr_data(wdat), .o_rd_en(ren));
    cfs_regs cfs_regs_inst (.I_REF_CLK(clk), .I_RST(rst), .I_ADDR(addr), .I_WR_EN(wen), .I_WR_DATA(wdat),
        .I_RD_EN(ren), .I_STATUS_PINS(pins), .O_RD_DATA(rdat), .O_RD_VALID(rvld), .O_VOLT_EVENT_IRQ(virq),
        .O_CURR_EVENT_IRQ(cirq), .O_SAFETY_TIMER_RESTART(srst), .O_CHARGE_CTL(ctl));

    // pulse counters and a hang guard; 3000 cycles is far beyond the sequence
    always @(posedge clk)
    begin
        cycles++;
        vcnt += (virq === 1'b1);
        ccnt += (cirq === 1'b1);
        scnt += (srst === 1'b1);
        if (cycles == 3000)
        begin
            bad_count++;
            end_of_test();
        end
    end

    task automatic check(input string n, input logic [35:0] seen, input logic [35:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("BAD %s expected %h seen %h", n, exp, seen);
        end
    endtask

    task automatic end_of_test;
        if (bad_count == 0 && comparisons > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // read a register and compare
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        cfs_host_inst.rd(a, got);
        check("register", 36'(got), 36'(e));
    endtask

    // set pins, let the two sync flops settle, then read
    task automatic pin_case(input logic [16:0] p, input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        #2;
        pins = p;
        repeat (4) @(posedge clk);
        rd_chk(a, e);
    endtask

    // ************************************************************
    // main sequence
    // ************************************************************
    initial
    begin
        repeat (6) @(posedge clk);
        #2;
        rst = 1'b0;
        repeat (3) @(posedge clk);
        check("ctl", ctl, {2'b00, cfs_pkg::PCT_100, 1'b1, cfs_pkg::COOL_THR_1, cfs_pkg::WARM_THR_1});
        rd_chk(8'h0C, 8'h75);
        rd_chk(8'h0A, 8'h00);
        rd_chk(8'h0B, 8'h52);
        rd_chk(8'h10, 8'h00);
        // fault byte: watchdog, boost causes, charge codes, battery, zones
        pin_case(17'h1_0000, 8'h09, 8'h80);
        pin_case(17'h0_8000, 8'h09, 8'h40);
        pin_case(17'h0_4000, 8'h09, 8'h40);
        pin_case(17'h0_2000, 8'h09, 8'h40);
        pin_case(17'h0_1000, 8'h09, 8'h10);
        pin_case(17'h0_0800, 8'h09, 8'h10);
        pin_case(17'h0_0400, 8'h09, 8'h20);
        pin_case(17'h0_0200, 8'h09, 8'h30);
        pin_case(17'h0_1600, 8'h09, 8'h10);
        pin_case(17'h0_0100, 8'h09, 8'h08);
        pin_case(17'h0_00A0, 8'h09, 8'h02);
        pin_case(17'h0_0060, 8'h09, 8'h03);
        pin_case(17'h0_0040, 8'h09, 8'h00);
        pin_case(17'h0_0000, 8'h09, 8'h00);
        // input byte: live status levels
        pin_case(17'h0_0010, 8'h0A, 8'h80);
        pin_case(17'h0_0008, 8'h0A, 8'h40);
        pin_case(17'h0_0004, 8'h0A, 8'h20);
        pin_case(17'h0_0002, 8'h0A, 8'h08);
        pin_case(17'h0_0001, 8'h0A, 8'h04);
        check("volt irq", 36'(vcnt), 36'h1);
        check("curr irq", 36'(ccnt), 36'h1);
        // masked loop rises must stay silent
        cfs_host_inst.wr(8'h0A, 8'hFF);
        pin_case(17'h0_000C, 8'h0A, 8'h63);
        check("volt irq", 36'(vcnt), 36'h1);
        check("curr irq", 36'(ccnt), 36'h1);
        // register reset restores writable bits and self-clears
        cfs_host_inst.wr(8'h0C, 8'h00);
        rd_chk(8'h0C, 8'h00);
        cfs_host_inst.wr(8'h0B, 8'h80);
        repeat (3) @(posedge clk);
        rd_chk(8'h0B, 8'h52);
        rd_chk(8'h0A, 8'h60);
        rd_chk(8'h0C, 8'h75);
        check("restart", 36'(scnt), 36'h1);
        // cool zone: voltage capped, charging inhibited, lowest-index thresholds
        cfs_host_inst.wr(8'h0C, 8'h90);
        pin_case(17'h0_0060, 8'h0C, 8'h90);
        check("ctl", ctl, {2'b11, cfs_pkg::PCT_100, 1'b1, cfs_pkg::COOL_THR_0, cfs_pkg::WARM_THR_0});
        // warm zone: 20 percent current, no doubled timer
        pin_case(17'h0_00A0, 8'h09, 8'h02);
        check("ctl", ctl, {2'b00, cfs_pkg::PCT_20, 1'b0, cfs_pkg::COOL_THR_0, cfs_pkg::WARM_THR_0});
        // warm current codes 10 and 00 and upper threshold codes, still in the warm zone
        cfs_host_inst.wr(8'h0C, 8'h2A);
        rd_chk(8'h0C, 8'h2A);
        check("ctl", ctl, {2'b00, cfs_pkg::PCT_50, 1'b0, cfs_pkg::COOL_THR_2, cfs_pkg::WARM_THR_2});
        cfs_host_inst.wr(8'h0C, 8'h0F);
        rd_chk(8'h0C, 8'h0F);
        check("ctl", ctl, {2'b00, cfs_pkg::PCT_0, 1'b0, cfs_pkg::COOL_THR_3, cfs_pkg::WARM_THR_3});
        // watchdog expiry restores controls and blocks writes
        pin_case(17'h1_0000, 8'h0C, 8'h75);
        cfs_host_inst.wr(8'h0C, 8'h00);
        rd_chk(8'h0C, 8'h75);
        end_of_test();
    end
endmodule // testbench
